// ==== fpe_pkg.sv ====
// Purpose: Constants for the flash erase/protect host controller
// Assumes: Device status byte read on low data lines while in status mode
// Notes: Register offsets and the clear-status code are host-side choices
`default_nettype none
package fpe_pkg;
    // Host register offsets
    localparam logic [3:0] REG_CTRL   = 4'h0; // W: [0] go, [1] chip, [2] protect level, [3] clear status; R: [1] chip, [2] protect level
    localparam logic [3:0] REG_ADDR   = 4'h4; // RW: target block address
    localparam logic [3:0] REG_STAT   = 4'h8; // R: [0] busy, [1] done, [15:8] last status byte
    localparam logic [3:0] REG_XSTAT  = 4'hC; // R: [7] multi write available (masked)
    localparam int         CTRL_GO    = 0;
    localparam int         CTRL_CHIP  = 1;
    localparam int         CTRL_WP    = 2;
    localparam int         CTRL_CLR   = 3;
    // Device commands
    localparam logic [7:0] CMD_RDSR   = 8'h70;
    localparam logic [7:0] CMD_BERASE = 8'h20;
    localparam logic [7:0] CMD_CERASE = 8'h30;
    localparam logic [7:0] CMD_CONF   = 8'hD0;
    localparam logic [7:0] CMD_ARRAY  = 8'hFF;
    localparam logic [7:0] CMD_CLRSR  = 8'h50;
    // Status bit positions and masks
    localparam int         SR_READY   = 7;
    localparam logic [7:0] SR_MASK    = 8'hFE;
    localparam logic [7:0] XSR_MASK   = 8'h80;
    // Bus timing: strobe width in cycles
    localparam int         T_STROBE_NS = 80;
    localparam int         CLK_NS      = 8;
    localparam logic [3:0] STROBE_CYC  = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam int         AW          = 21;
    typedef enum logic [6:0] {
        FPE_IDLE  = 7'h01,
        FPE_WR    = 7'h02,
        FPE_RD    = 7'h04,
        FPE_CHK   = 7'h08,
        FPE_NEXT  = 7'h10,
        FPE_DONE  = 7'h20,
        FPE_GAP   = 7'h40
    } fpe_state_t;
endpackage : fpe_pkg
`default_nettype wire

// ==== fpe_sync.sv ====
// Purpose: Two-flop synchroniser for device pins
// Assumes: Single clock domain
// Notes: First stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module fpe_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    // Metastability guard
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
        end
    end
    assign q_o = s2_reg;
endmodule : fpe_sync
`default_nettype wire

// ==== fpe_host.sv ====
// Purpose: Host sequencer issuing block/chip erase and polling device status
// Assumes: Device bus is asynchronous; strobes held STROBE_CYC cycles
// Notes: Protect level is a software choice driven on fwp_n_o
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fpe_host (
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic [3:0]           addr_i,
    input  wire logic [31:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [31:0]          rdata_o,
    output logic      [fpe_pkg::AW-1:0] fa_o,
    output logic      [7:0]           fdq_o,
    output logic                      fdq_oe_o,
    input  wire logic [7:0]           fdq_i,
    output logic                      fce_n_o,
    output logic                      fwe_n_o,
    output logic                      foe_n_o,
    output logic                      fwp_n_o
);
    fpe_pkg::fpe_state_t st_reg, st_next;
    logic [3:0]             cnt_reg, cnt_next;
    logic [1:0]             step_reg, step_next;   // Command index within sequence
    logic                   chip_reg, chip_next;
    logic                   wp_reg, wp_next;
    logic                   done_reg, done_next;
    logic [fpe_pkg::AW-1:0] ba_reg, ba_next;
    logic [7:0]             sr_reg, sr_next;
    logic [7:0]             xsr_reg, xsr_next;
    logic [7:0]             cmd_reg, cmd_next;
    logic                   clr_reg, clr_next;
    logic [31:0]            rdata_reg, rdata_next;
    logic                   we_reg, we_next, oe_next;
    logic [7:0]             dq_s;

    fpe_sync #(.W(8)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (fdq_i),
        .q_o      (dq_s)
    );

    // Command of each step: status read, setup, confirm, back to array
    function automatic logic [7:0] step_cmd(input logic [1:0] s, input logic chip);
        case (s)
            2'd0:    step_cmd = fpe_pkg::CMD_RDSR;
            2'd1:    step_cmd = chip ? fpe_pkg::CMD_CERASE : fpe_pkg::CMD_BERASE;
            2'd2:    step_cmd = fpe_pkg::CMD_CONF;
            default: step_cmd = fpe_pkg::CMD_ARRAY;
        endcase
    endfunction : step_cmd

    // Sequencer next state
    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        step_next  = step_reg;
        chip_next  = chip_reg;
        wp_next    = wp_reg;
        done_next  = done_reg;
        ba_next    = ba_reg;
        sr_next    = sr_reg;
        xsr_next   = xsr_reg;
        cmd_next   = cmd_reg;
        clr_next   = clr_reg;
        we_next    = 1'b0;
        oe_next    = 1'b0;
        rdata_next = 32'h0000_0000;
        if (wr_i && addr_i == fpe_pkg::REG_ADDR)
            ba_next = wdata_i[fpe_pkg::AW-1:0];
        if (rd_i) begin
            case (addr_i)
                fpe_pkg::REG_CTRL:  rdata_next = {29'h0, wp_reg, chip_reg, 1'b0};
                fpe_pkg::REG_ADDR:  rdata_next = {11'h000, ba_reg};
                fpe_pkg::REG_STAT:  rdata_next = {16'h0000, sr_reg, 6'h00, done_reg, st_reg != fpe_pkg::FPE_IDLE};
                fpe_pkg::REG_XSTAT: rdata_next = {24'h000000, xsr_reg};
                default:            rdata_next = 32'h0000_0000;
            endcase
        end
        case (st_reg)
            fpe_pkg::FPE_IDLE: begin
                if (wr_i && addr_i == fpe_pkg::REG_CTRL) begin
                    wp_next = wdata_i[fpe_pkg::CTRL_WP];
                    if (wdata_i[fpe_pkg::CTRL_CLR]) begin
                        cmd_next = fpe_pkg::CMD_CLRSR; // Errors stick in device until this
                        clr_next = 1'b1;
                        cnt_next = '0;
                        st_next  = fpe_pkg::FPE_WR;
                    end else if (wdata_i[fpe_pkg::CTRL_GO]) begin
                        chip_next = wdata_i[fpe_pkg::CTRL_CHIP];
                        done_next = 1'b0;
                        clr_next  = 1'b0;
                        step_next = 2'd0;
                        cmd_next  = fpe_pkg::CMD_RDSR;
                        cnt_next  = '0;
                        st_next   = fpe_pkg::FPE_WR;
                    end
                end
            end
            fpe_pkg::FPE_WR: begin
                we_next  = 1'b1;
                cnt_next = cnt_reg + 4'd1;
                if (cnt_reg == fpe_pkg::STROBE_CYC) begin
                    we_next  = 1'b0;
                    cnt_next = '0;
                    if (clr_reg) begin
                        clr_next = 1'b0;
                        st_next  = fpe_pkg::FPE_IDLE;
                    end else if (step_reg == 2'd1) begin
                        st_next = fpe_pkg::FPE_NEXT; // Setup goes straight to confirm
                    end else if (step_reg == 2'd3) begin
                        st_next = fpe_pkg::FPE_DONE;
                    end else begin
                        st_next = fpe_pkg::FPE_GAP;   // After 70H or D0H, poll
                    end
                end
            end
            fpe_pkg::FPE_GAP: begin
                st_next = fpe_pkg::FPE_RD;
            end
            fpe_pkg::FPE_RD: begin
                oe_next  = 1'b1;
                cnt_next = cnt_reg + 4'd1;
                if (cnt_reg == fpe_pkg::STROBE_CYC) begin
                    oe_next  = 1'b0;
                    cnt_next = '0;
                    sr_next  = dq_s & fpe_pkg::SR_MASK;
                    st_next  = fpe_pkg::FPE_CHK;
                end
            end
            fpe_pkg::FPE_CHK: begin
                if (!sr_reg[fpe_pkg::SR_READY]) begin
                    st_next = fpe_pkg::FPE_RD;
                end else begin
                    st_next = fpe_pkg::FPE_NEXT;
                end
            end
            fpe_pkg::FPE_NEXT: begin
                step_next = (step_reg == 2'd2) ? 2'd3 : step_reg + 2'd1;
                cmd_next  = step_cmd((step_reg == 2'd2) ? 2'd3 : step_reg + 2'd1, chip_reg);
                if (step_reg == 2'd2)
                    xsr_next = sr_reg & fpe_pkg::XSR_MASK;
                st_next   = fpe_pkg::FPE_WR;
            end
            fpe_pkg::FPE_DONE: begin
                done_next = 1'b1; // Error bits 5,4,3,1 left in sr for software
                st_next   = fpe_pkg::FPE_IDLE;
            end
            default: st_next = fpe_pkg::FPE_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_reg    <= fpe_pkg::FPE_IDLE;
            cnt_reg   <= '0;
            step_reg  <= '0;
            chip_reg  <= 1'b0;
            wp_reg    <= 1'b0;
            done_reg  <= 1'b0;
            ba_reg    <= '0;
            sr_reg    <= 8'h00;
            xsr_reg   <= 8'h00;
            cmd_reg   <= 8'h00;
            clr_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            we_reg    <= 1'b0;
        end else begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            step_reg  <= step_next;
            chip_reg  <= chip_next;
            wp_reg    <= wp_next;
            done_reg  <= done_next;
            ba_reg    <= ba_next;
            sr_reg    <= sr_next;
            xsr_reg   <= xsr_next;
            cmd_reg   <= cmd_next;
            clr_reg   <= clr_next;
            rdata_reg <= rdata_next;
            we_reg    <= we_next;
        end
    end

    // Pin state; strobes are kept active low so every pin leaves straight from a flop
    logic [fpe_pkg::AW-1:0] fa_reg, fa_next;
    logic                   ce_n_reg, ce_n_next;
    logic                   we_n_reg, we_n_next;
    logic                   oe_n_reg, oe_n_next;

    // Pin next values follow the strobe requests, so select, write and read stay aligned
    always_comb begin
        fa_next   = ba_reg;                   // Block address serves chip erase too
        we_n_next = ~we_next;
        oe_n_next = ~oe_next;
        ce_n_next = ~(we_next | oe_next);     // Select spans each strobe, never a gap inside it
    end

    // Pin registers; protect level decides ..outcomes inside the device
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fa_reg   <= '0;
            ce_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
        end else begin
            fa_reg   <= fa_next;
            ce_n_reg <= ce_n_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
        end
    end
    assign fa_o     = fa_reg;
    assign fdq_o    = cmd_reg;
    assign fdq_oe_o = we_reg;                 // Data lines driven only under the write strobe
    assign fwe_n_o  = we_n_reg;
    assign foe_n_o  = oe_n_reg;
    assign fce_n_o  = ce_n_reg;
    assign fwp_n_o  = wp_reg;
    assign rdata_o  = rdata_reg;
endmodule : fpe_host
`default_nettype wire

// ==== fpe_host_monitor.sv ====
// Purpose: Checks command order and status masking at the host ports
// Assumes: A command is issued when the write strobe falls
// Notes: Ready is judged from the last byte seen during a read strobe
`timescale 1ns/1ps
`default_nettype none
module fpe_host_monitor (
    input wire logic                   clk_i,
    input wire logic                   resetn_i,
    input wire logic [3:0]             addr_i,
    input wire logic                   rd_i,
    input wire logic [31:0]            rdata_o,
    input wire logic [fpe_pkg::AW-1:0] fa_o,
    input wire logic [7:0]             fdq_o,
    input wire logic [7:0]             fdq_i,
    input wire logic                   fwe_n_o,
    input wire logic                   foe_n_o,
    input wire logic                   fdq_oe_o,
    input wire logic                   fce_n_o
);
    logic [7:0]             cmd_reg;
    logic [7:0]             rdb_reg;
    logic [fpe_pkg::AW-1:0] blk_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Last command, erase target and last status byte; FF start keeps early edges quiet
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cmd_reg <= 8'hFF;
            rdb_reg <= 8'h00;
            blk_reg <= '0;
        end else begin
            if ($fell(fwe_n_o)) cmd_reg <= fdq_o;
            if ($fell(fwe_n_o) && fdq_o == 8'h20) blk_reg <= fa_o;
            if (!foe_n_o) rdb_reg <= fdq_i;
        end
    end
    sequence s_cmd(logic [7:0] c);
        $fell(fwe_n_o) && fdq_o == c;
    endsequence
    chk_setup_after_poll: assert property ((s_cmd(8'h20) or s_cmd(8'h30)) |-> cmd_reg == 8'h70)
        else $error("erase setup without status command first");
    chk_confirm_follows_setup: assert property (s_cmd(8'hD0) |-> cmd_reg inside {8'h20, 8'h30})
        else $error("confirm not preceded by erase setup");
    chk_confirm_same_block: assert property (s_cmd(8'hD0) ##0 cmd_reg == 8'h20 |-> fa_o == blk_reg)
        else $error("confirm address left the target block");
    chk_array_after_confirm: assert property (s_cmd(8'hFF) |-> cmd_reg inside {8'hD0, 8'h50})
        else $error("array read command out of order");
    chk_act_on_ready: assert property ((s_cmd(8'h20) or s_cmd(8'h30) or s_cmd(8'hFF)) |-> rdb_reg[7])
        else $error("next command issued while device busy");
    chk_stat_bit0_masked: assert property (rd_i && addr_i == fpe_pkg::REG_STAT |=> rdata_o[8] == 1'b0)
        else $error("reserved status bit not masked");
    chk_xstat_masked: assert property (rd_i && addr_i == fpe_pkg::REG_XSTAT |=> rdata_o[6:0] == 7'h00)
        else $error("reserved extended status bits not masked");
    chk_write_drives_bus: assert property (!fwe_n_o |-> fdq_oe_o && !fce_n_o)
        else $error("write strobe without data drive or select");
    chk_read_releases_bus: assert property (!foe_n_o |-> !fdq_oe_o && !fce_n_o)
        else $error("read strobe while host drives data lines");
endmodule : fpe_host_monitor
bind fpe_host fpe_host_monitor mon_u (.clk_i, .resetn_i, .addr_i, .rd_i, .rdata_o, .fa_o, .fdq_o, .fdq_i,
    .fwe_n_o, .foe_n_o, .fdq_oe_o, .fce_n_o);
`default_nettype wire

// ==== fpe_flash_model.sv ====
// Purpose: Behavioural flash device answering erase and status commands
// Assumes: Block number is the top two address bits
// Notes: Busy status carries junk low bits so a careless host is caught
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model #(
    parameter logic [3:0] LOCKS = 4'h5
) (
    input  wire logic                   ce_n_i,
    input  wire logic                   we_n_i,
    input  wire logic                   oe_n_i,
    input  wire logic                   wp_n_i,
    input  wire logic [fpe_pkg::AW-1:0] a_i,
    input  wire logic [7:0]             d_i,
    output logic      [7:0]             q_o
);
    logic [3:0] erased, locks;
    logic [7:0] sr, cmd, last, st;
    int         busy;
    // Reserved bit 0 set on purpose; no suspend, no voltage fault
    initial begin
        erased = 4'h0;
        locks = LOCKS;
        sr = 8'h81;
        cmd = 8'hFF;
        last = 8'h00;
        busy = 0;
    end
    // Command latched on the rising write strobe
    always @(posedge we_n_i) begin
        if (d_i == 8'hD0 && cmd == 8'h20) begin
            if (locks[a_i[fpe_pkg::AW-1 -: 2]] && !wp_n_i) sr = sr | 8'h22;
            else erased[a_i[fpe_pkg::AW-1 -: 2]] = 1'b1;
            busy = 3;
        end else if (d_i == 8'hD0 && cmd == 8'h30) begin
            erased = erased | (wp_n_i ? 4'hF : ~locks);
            busy = 3;
        end else if (d_i == 8'hD0 && cmd == 8'h60) begin
            if (!wp_n_i) sr = sr | 8'h22;
            else locks = 4'h0;
            busy = 3;
        end else if (d_i == 8'h01 && cmd == 8'h60) begin
            if (!wp_n_i) sr = sr | 8'h12;
            else locks[a_i[fpe_pkg::AW-1 -: 2]] = 1'b1;
            busy = 3;
        end else if (d_i == 8'hD0) sr = sr | 8'h30;
        else if (d_i == 8'h50) sr = 8'h81;
        cmd = d_i;
    end
    assign st = (busy == 0) ? sr : 8'h7F;
    // Released lines show the inverse of the last byte
    always @(posedge oe_n_i) begin
        last = st;
        if (busy > 0) busy = busy - 1;
    end
    assign q_o = (!oe_n_i && !ce_n_i) ? st : ~last;
endmodule : fpe_flash_model
`default_nettype wire

// ==== fpe_host_tb.sv ====
// Purpose: Erase and protect scenarios through the host registers
// Assumes: Blocks 0 and 2 are locked in the device model
// Notes: Status expectations exclude the masked reserved bit
`timescale 1ns/1ps
`default_nettype none
module fpe_host_tb;
    logic                   clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0]             addr_i = 4'h0;
    logic [31:0]            wdata_i = 32'h0, rdata_o, d;
    logic [fpe_pkg::AW-1:0] fa_o;
    logic [7:0]             fdq_o, fdq_i;
    logic                   fdq_oe_o, fce_n_o, fwe_n_o, foe_n_o, fwp_n_o;
    int                     n_errors = 0, total_checks = 0;
    fpe_host dut_u (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .fa_o, .fdq_o, .fdq_oe_o,
        .fdq_i, .fce_n_o, .fwe_n_o, .foe_n_o, .fwp_n_o);
    fpe_flash_model fl_u (.ce_n_i(fce_n_o), .we_n_i(fwe_n_o), .oe_n_i(foe_n_o), .wp_n_i(fwp_n_o),
        .a_i(fa_o), .d_i(fdq_o), .q_o(fdq_i));
    task automatic tally_and_finish();
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // One erase run; the poll is bounded so a stuck sequencer ends the whole simulation
    task automatic op(input logic [1:0] blk, input logic chip, input logic wp, input logic [7:0] es);
        int i;
        wr(fpe_pkg::REG_ADDR, 32'(blk) << (fpe_pkg::AW - 2));
        wr(fpe_pkg::REG_CTRL, {29'h0, wp, chip, 1'b1});
        repeat (4) @(posedge clk_i);
        for (i = 0; i < 4000; i++) begin
            rd(fpe_pkg::REG_STAT);
            if (d[1:0] === 2'b10) break;
        end
        if (i == 4000) begin
            n_errors++;
            tally_and_finish();
        end else begin
            chk("status byte", {24'h0, d[15:8]}, {24'h0, es});
        end
    endtask : op
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(4'h2);
        chk("unmapped read", d, 32'h0);
        op(2'd1, 1'b0, 1'b0, 8'h80);
        chk("erased after unlocked", {28'h0, fl_u.erased}, 32'h2);
        op(2'd0, 1'b0, 1'b0, 8'hA2);
        chk("erased after locked", {28'h0, fl_u.erased}, 32'h2);
        op(2'd3, 1'b0, 1'b0, 8'hA2);
        wr(fpe_pkg::REG_CTRL, 32'h8);
        repeat (200) @(posedge clk_i);
        op(2'd2, 1'b0, 1'b1, 8'h80);
        chk("erased after override", {28'h0, fl_u.erased}, 32'hE);
        op(2'd0, 1'b1, 1'b0, 8'h80);
        chk("chip erase protected", {28'h0, fl_u.erased}, 32'hE);
        op(2'd0, 1'b1, 1'b1, 8'h80);
        chk("chip erase override", {28'h0, fl_u.erased}, 32'hF);
        rd(fpe_pkg::REG_XSTAT);
        chk("extended status", d, 32'h80);
        tally_and_finish();
    end
endmodule : fpe_host_tb
`default_nettype wire
